/* lrcb_div.sv */
// Purpose: Tick divider with pulse and square-wave outputs
// Assumes: DIV is even and at least two
// Notes:   clr_i restarts the count
`timescale 1ns/1ns
`default_nettype none
module lrcb_div #(
  parameter int DIV = 4
) (
  input  wire logic ref_clk_i, // System clock
  input  wire logic rstn_i,    // Sync reset, active low
  input  wire logic clr_i,     // Restart count
  input  wire logic tick_i,    // Input tick
  output logic      tick_o,    // One tick per DIV inputs
  output logic      wave_o     // Square wave, period DIV
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF = CW'(DIV / 2);
  logic [CW-1:0] cnt_r; // Input tick count
  logic [CW-1:0] cnt_nxt;
  logic          wrap;
  assign wrap    = tick_i & (cnt_r == LAST);
  assign cnt_nxt = wrap ? '0 : cnt_r + CW'(1);
  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || clr_i) begin
      cnt_r <= '0;
    end else if (tick_i) begin
      cnt_r <= cnt_nxt;
    end
  end
  assign tick_o = wrap;
  assign wave_o = (cnt_r >= HALF);
endmodule
`default_nettype wire

/* lrcb_edge.sv */
// Purpose: Rising edge detector for a sampled oscillator level
// Assumes: Input already synchronous to ref_clk_i
// Notes:   Pulse and registered copy
`timescale 1ns/1ns
`default_nettype none
module lrcb_edge (
  input  wire logic ref_clk_i, // System clock
  input  wire logic rstn_i,    // Sync reset, active low
  input  wire logic level_i,   // Oscillator level
  output logic      level_o,   // Registered level
  output logic      rise_o     // Rising edge pulse
);
  logic level_r; // Previous sample
  // ****************************************
  // Sample register
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_i;
    end
  end
  assign level_o = level_r;
  assign rise_o  = level_i & ~level_r;
endmodule
`default_nettype wire

/* lrcb_pkg.sv */
// Purpose: Shared constants and types for the LCD regulator clock block
// Assumes: One register word per 32-bit AXI4-Lite slot
// Notes:   Offsets are byte addresses
`default_nettype none
package lrcb_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFF_REG_CTRL = 4'h0; // Regulator control
  localparam logic [3:0] OFF_TIM_CTRL = 4'h4; // Timing select, status
  localparam logic [7:0] REG_RESET    = 8'h3c; // Bias 111, third on
  localparam logic [7:0] REG_WMASK    = 8'h7f; // Top bit not stored
  localparam int PSEL_LSB   = 0;  // Pump clock select
  localparam int THIRD_BIT  = 2;  // Third bias enable
  localparam int BIAS_LSB   = 3;  // Bias level field
  localparam int PUMP_BIT   = 6;  // Pump enable
  localparam int TSEL_LSB   = 0;  // Timing clock select
  localparam int SEG32_BIT  = 4;  // Segment 32 available
  localparam int CFG_LSB    = 5;  // Bias configuration
  localparam int PCLK_BIT   = 7;  // Pump clock level
  localparam logic [1:0] TSEL_RESET = 2'h0;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] SEL_OFF  = 2'h0; // Regulator disabled
  localparam logic [1:0] SEL_T1   = 2'h1; // Timer1 oscillator
  localparam logic [1:0] SEL_FAST = 2'h2; // Fast oscillator
  localparam logic [1:0] SEL_RC   = 2'h3; // Internal RC
  localparam logic [1:0] TSEL_SYS = 2'h0; // System clock / 4
  localparam logic [1:0] TSEL_T1  = 2'h1; // Timer1 oscillator
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Dividers
  // ****************************************
  localparam int PUMP_PRESCALE = 256;  // Fast osc to pump
  localparam int SYS_PREDIV    = 4;    // System clock / 4
  localparam int SYS_PRESCALE  = 8192; // System path postscale
  localparam int OSC_PRESCALE  = 32;   // Slow osc postscale
  // Bias circuit configuration
  typedef enum logic [1:0] {
    CFG_BOOSTED, CFG_UNBOOSTED, CFG_LADDER_SOFT, CFG_LADDER_HARD
  } lrcb_cfg_t;
  // Analog control bundle
  typedef struct packed {
    lrcb_cfg_t  cfg;          // Bias configuration
    logic       regulator_en; // Regulator powered
    logic       vref_en;      // Internal reference on
    logic       pump_on;      // Charge pump running
    logic [2:0] bias_level;   // Peak level code
    logic       third_bias;   // 1: third bias, 0: static
    logic       flyback_gpio; // Flyback pins to port
  } lrcb_bias_t;
endpackage
`default_nettype wire

/* lrcb_sva.sv */
// Purpose: Port assertions for the regulator clock block
// Assumes: Watches ports of lrcb_top only
// Notes:   Bound into every lrcb_top instance
`timescale 1ns/1ns
`default_nettype none
module lrcb_chk (
  input wire logic                 ref_clk_i,
  input wire logic                 rstn_i,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic                 timer1_osc_enable_i,
  input wire logic                 pump_clk_o,
  input wire logic                 seg32_available_o,
  input wire lrcb_pkg::lrcb_bias_t bias_ctrl_o
);
  // ****************************************
  // Helpers
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic live_r; // Out of reset a full cycle
  wire lrcb_pkg::lrcb_cfg_t cfg = bias_ctrl_o.cfg; // Decoded configuration
  // Masks the reset value still showing on the first edge
  always_ff @(posedge ref_clk_i) begin
    live_r <= rstn_i;
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_seg32_timer1: assert property (timer1_osc_enable_i |-> !seg32_available_o)
    else $error("segment 32 not blocked");
  a_boost_pump: assert property (live_r && cfg == lrcb_pkg::CFG_BOOSTED |->
    bias_ctrl_o.pump_on && bias_ctrl_o.regulator_en)
    else $error("boost controls wrong");
  a_unboost_nopump: assert property (live_r && cfg == lrcb_pkg::CFG_UNBOOSTED |->
    !bias_ctrl_o.pump_on && bias_ctrl_o.regulator_en)
    else $error("unboost controls wrong");
  a_soft_gpio: assert property (live_r && cfg == lrcb_pkg::CFG_LADDER_SOFT |->
    bias_ctrl_o.flyback_gpio && bias_ctrl_o.vref_en && !bias_ctrl_o.pump_on)
    else $error("soft controls wrong");
  a_hard_off: assert property (live_r && cfg == lrcb_pkg::CFG_LADDER_HARD |->
    !bias_ctrl_o.regulator_en && !bias_ctrl_o.vref_en && !bias_ctrl_o.flyback_gpio)
    else $error("hard controls wrong");
  a_pump_gated: assert property ((live_r && cfg[1])[*3] |-> !pump_clk_o)
    else $error("pump clock not gated");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> // bus
    ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) // bus
    else $error("write response dropped");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // bus
    else $error("read response late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) // bus
    else $error("read data dropped");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule
bind lrcb_top lrcb_chk u_chk (.*);
`default_nettype wire

/* lrcb_top.sv */
// Purpose: LCD regulator clock and bias mode control, AXI4-Lite slave
// Assumes: Oscillator levels arrive synchronous to ref_clk_i;
//          ref_clk_i stands in for the system clock
// Notes:   Analog ladder and pump are outside
//
// Overview of operation
// - Pump clock is own branch, nominal 31 kHz
// - Fast oscillator divided by 256 for pump
// - Select 11 RC, 10 fast, 01 Timer1, 00 off
// - System clock timing path divides by 4, then by 8192
// - Timer1 and RC keep running in Sleep
// - Timer1 in use removes segment 32
// - Bit 6 turns the charge pump on when select is nonzero
// - Bits 5-3 set peak bias level
// - Bit 2 picks third or static bias
// - Top register bit reads zero
// - Select nonzero, pump on: boosted configuration
// - Select nonzero, pump off: unboosted configuration
// - Regulator configurations: static or third bias only
// - Select zero, pump on: ladder soft contrast
// - Soft contrast frees flyback pins as port
// - Both clear: regulator and reference fully off
// - Timing select 1x RC, 01 Timer1, 00 system
`timescale 1ns/1ns
`default_nettype none
module lrcb_top (
  input  wire logic              ref_clk_i,         // 125 MHz clock
  input  wire logic              rstn_i,            // Sync reset, low
  // AXI4-Lite slave
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Oscillators and device state
  input  wire logic              internal_rc_osc_i,   // RC level
  input  wire logic              timer1_osc_i,        // Timer1 level
  input  wire logic              internal_fast_osc_i, // 8 MHz level
  input  wire logic              timer1_osc_enable_i, // Timer1 in use
  input  wire logic              sleep_i,             // Sleep mode
  // Outputs
  output logic                   pump_clk_o,          // Pump clock
  output logic                   lcd_base_tick_o,     // Timing tick
  output logic                   seg32_available_o,   // Segment 32 ok
  output lrcb_pkg::lrcb_bias_t   bias_ctrl_o          // Bias controls
);
  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]  reg_ctrl_r;   // Regulator control
  logic [7:0]  reg_ctrl_nxt;
  logic [1:0]  tsel_r;       // Timing clock select
  logic [1:0]  tsel_nxt;
  // Write channel holding
  logic        aw_full_r;    // Address captured
  logic [3:0]  aw_addr_r;
  logic        w_full_r;     // Data captured
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  // Read channel
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  // Output registers
  logic        pump_clk_r;
  logic        base_tick_r;

  // ****************************************
  // Field decode
  // ****************************************
  wire [1:0] pump_clock_select = reg_ctrl_r[lrcb_pkg::PSEL_LSB +: 2];
  wire       pump_enable       = reg_ctrl_r[lrcb_pkg::PUMP_BIT];
  wire       third_bias_enable = reg_ctrl_r[lrcb_pkg::THIRD_BIT];
  wire [2:0] bias_level        = reg_ctrl_r[lrcb_pkg::BIAS_LSB +: 3];
  wire       sel_off           = (pump_clock_select == lrcb_pkg::SEL_OFF);

  // Word address match
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a[3:2] == off[3:2]);
  endfunction

  // ****************************************
  // Oscillator edge detection
  // ****************************************
  logic rc_lvl;   // RC sampled level
  logic rc_rise;
  logic t1_lvl;   // Timer1 sampled level
  logic t1_rise;
  logic fast_rise;

  lrcb_edge u_edge_rc (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .level_i   (internal_rc_osc_i),
    .level_o   (rc_lvl),
    .rise_o    (rc_rise)
  );
  lrcb_edge u_edge_t1 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .level_i   (timer1_osc_i),
    .level_o   (t1_lvl),
    .rise_o    (t1_rise)
  );
  lrcb_edge u_edge_fast (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .level_i   (internal_fast_osc_i),
    .level_o   (),
    .rise_o    (fast_rise)
  );

  // ****************************************
  // Charge pump clock branch
  // ****************************************
  // fast oscillator prescale
  // Fast source halts in Sleep
  logic fast_div_wave;
  lrcb_div #(.DIV(lrcb_pkg::PUMP_PRESCALE)) u_div_pump (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .clr_i     (pump_clock_select != lrcb_pkg::SEL_FAST),
    .tick_i    (fast_rise & ~sleep_i),
    .tick_o    (),
    .wave_o    (fast_div_wave)
  );

  logic pump_src;
  always_comb begin
    case (pump_clock_select)
      lrcb_pkg::SEL_RC:   pump_src = rc_lvl;
      lrcb_pkg::SEL_FAST: pump_src = fast_div_wave;
      lrcb_pkg::SEL_T1:   pump_src = t1_lvl;
      default:            pump_src = 1'b0;
    endcase
  end

  wire pump_clk_nxt = pump_src & ~sel_off & pump_enable;

  // Registered so a select change cannot glitch it
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pump_clk_r <= 1'b0;
    end else begin
      pump_clk_r <= pump_clk_nxt;
    end
  end
  assign pump_clk_o = pump_clk_r;

  // ****************************************
  // LCD timing clock branch
  // ****************************************
  // System clock / 4 stand-in; halted in Sleep
  logic sys_q_tick;
  lrcb_div #(.DIV(lrcb_pkg::SYS_PREDIV)) u_div_sysq (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .clr_i     (sleep_i),
    .tick_i    (1'b1),
    .tick_o    (sys_q_tick),
    .wave_o    ()
  );

  logic sys_tick;
  lrcb_div #(.DIV(lrcb_pkg::SYS_PRESCALE)) u_div_sys (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .clr_i     (tsel_r != lrcb_pkg::TSEL_SYS),
    .tick_i    (sys_q_tick & ~sleep_i),
    .tick_o    (sys_tick),
    .wave_o    ()
  );

  wire osc_rise = tsel_r[1] ? rc_rise :
                  (tsel_r == lrcb_pkg::TSEL_T1) ? t1_rise : 1'b0;

  logic osc_tick;
  lrcb_div #(.DIV(lrcb_pkg::OSC_PRESCALE)) u_div_osc (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .clr_i     (tsel_r == lrcb_pkg::TSEL_SYS),
    .tick_i    (osc_rise),
    .tick_o    (osc_tick),
    .wave_o    ()
  );

  // Baseline tick register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      base_tick_r <= 1'b0;
    end else begin
      base_tick_r <= sys_tick | osc_tick;
    end
  end
  assign lcd_base_tick_o = base_tick_r;

  // ****************************************
  // Segment 32 availability
  // ****************************************
  // Timer1 use blocks segment
  wire t1_in_use = timer1_osc_enable_i
                 | (pump_clock_select == lrcb_pkg::SEL_T1)
                 | (tsel_r == lrcb_pkg::TSEL_T1);
  assign seg32_available_o = ~t1_in_use;

  // ****************************************
  // Bias configuration decode
  // ****************************************
  lrcb_pkg::lrcb_bias_t bias;
  always_comb begin
    bias            = '0;
    bias.bias_level = bias_level;
    bias.third_bias = third_bias_enable;
    case ({sel_off, pump_enable})
      2'b01: begin
        bias.cfg          = lrcb_pkg::CFG_BOOSTED;
        bias.regulator_en = 1'b1;
        bias.vref_en      = 1'b1;
        bias.pump_on      = 1'b1;
      end
      2'b00: begin
        bias.cfg          = lrcb_pkg::CFG_UNBOOSTED;
        bias.regulator_en = 1'b1;
        bias.vref_en      = 1'b1;
      end
      2'b11: begin
        bias.cfg          = lrcb_pkg::CFG_LADDER_SOFT;
        bias.vref_en      = 1'b1;
        bias.flyback_gpio = 1'b1;
      end
      default: begin
        bias.cfg          = lrcb_pkg::CFG_LADDER_HARD;
      end
    endcase
  end

  // Controls held in flops
  lrcb_pkg::lrcb_bias_t bias_r;
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      bias_r <= '0;
    end else begin
      bias_r <= bias;
    end
  end
  assign bias_ctrl_o = bias_r;

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  // Address and data taken in either order
  assign s_axi_awready = ~aw_full_r & ~bvalid_r;
  assign s_axi_wready  = ~w_full_r & ~bvalid_r;
  wire   aw_take       = s_axi_awvalid & s_axi_awready;
  wire   w_take        = s_axi_wvalid & s_axi_wready;
  wire   wr_go         = aw_full_r & w_full_r;
  wire   wr_ctrl       = wr_go & hit(aw_addr_r, lrcb_pkg::OFF_REG_CTRL);
  wire   wr_tim        = wr_go & hit(aw_addr_r, lrcb_pkg::OFF_TIM_CTRL);

  // Register next values, lane 0 only
  // top bit never stored
  assign reg_ctrl_nxt = (wr_ctrl & w_strb_r[0]) ?
                        (w_data_r[7:0] & lrcb_pkg::REG_WMASK) : reg_ctrl_r;
  assign tsel_nxt     = (wr_tim & w_strb_r[0]) ?
                        w_data_r[lrcb_pkg::TSEL_LSB +: 2] : tsel_r;

  // Channel capture
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_full_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // Write response and register update
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      bvalid_r   <= 1'b0;
      bresp_r    <= lrcb_pkg::RESP_OKAY;
      reg_ctrl_r <= lrcb_pkg::REG_RESET;
      tsel_r     <= lrcb_pkg::TSEL_RESET;
    end else begin
      reg_ctrl_r <= reg_ctrl_nxt;
      tsel_r     <= tsel_nxt;
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wr_ctrl | wr_tim) ? lrcb_pkg::RESP_OKAY
                                       : lrcb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign s_axi_arready = ~rvalid_r;
  wire   ar_take       = s_axi_arvalid & s_axi_arready;
  wire   rd_ctrl       = hit(s_axi_araddr, lrcb_pkg::OFF_REG_CTRL);
  wire   rd_tim        = hit(s_axi_araddr, lrcb_pkg::OFF_TIM_CTRL);

  // Timing status word
  logic [31:0] tim_word;
  always_comb begin
    tim_word = 32'h0000_0000;
    tim_word[lrcb_pkg::TSEL_LSB +: 2] = tsel_r;
    tim_word[lrcb_pkg::SEG32_BIT]     = seg32_available_o;
    tim_word[lrcb_pkg::CFG_LSB +: 2]  = bias_r.cfg;
    tim_word[lrcb_pkg::PCLK_BIT]      = pump_clk_r;
  end

  wire [31:0] rd_word = rd_ctrl ? {24'h00_0000,
                                   reg_ctrl_r & lrcb_pkg::REG_WMASK} :
                        rd_tim  ? tim_word : 32'h0000_0000;

  // Read data register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= lrcb_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= (rd_ctrl | rd_tim) ? lrcb_pkg::RESP_OKAY
                                     : lrcb_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule
`default_nettype wire

/* test_lcd_regulator_clock_and_bias_mode.sv */
// Purpose: Self-checking bench for the LCD regulator clock block
// Assumes: Oscillator levels change on bench clock edges
// Notes:   System timing path needs 32768 cycles per tick
`timescale 1ns/1ns
`default_nettype none
module test_lcd_regulator_clock_and_bias_mode;
  logic                 ref_clk_i, rstn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                 s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic                 s_axi_bvalid, s_axi_arready, s_axi_rvalid, pump_clk_o;
  logic                 internal_rc_osc_i, timer1_osc_i, internal_fast_osc_i;
  logic                 timer1_osc_enable_i, sleep_i, lcd_base_tick_o, seg32_available_o;
  logic [3:0]           s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]          s_axi_wdata, s_axi_rdata;
  logic [1:0]           s_axi_bresp, s_axi_rresp, rc_h, t1_h;
  lrcb_pkg::lrcb_bias_t bias_ctrl_o;
  logic                 fph_r;        // Fast oscillator half-rate phase
  int                   err_total, num_checks, rc_rises, t1_rises;
  lrcb_top u_dut (.*);
  // Clock at 125 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Timer1 and RC started, random levels
  // fast oscillator running, rises every 4
  always @(posedge ref_clk_i) begin
    internal_rc_osc_i <= 1'($urandom);
    timer1_osc_i <= 1'($urandom);
    fph_r <= ~fph_r;
    if (fph_r) internal_fast_osc_i <= ~internal_fast_osc_i;
    rc_h <= {rc_h[0], internal_rc_osc_i};
    t1_h <= {t1_h[0], timer1_osc_i};
    rc_rises <= rc_rises + int'(rc_h[0] & ~rc_h[1]);
    t1_rises <= t1_rises + int'(t1_h[0] & ~t1_h[1]);
  end
  // ****************************************
  // Checking and closing
  // ****************************************
  task chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task hang(input string m);
    err_total++;
    $display("wrong value at %0t ns: %s never answered", $time, m);
    end_sim();
  endtask
  // Expected bias controls
  function automatic lrcb_pkg::lrcb_bias_t exp_bias(input logic [7:0] v);
    lrcb_pkg::lrcb_bias_t e;
    e.cfg = (v[1:0] != 2'h0) ? (v[6] ? lrcb_pkg::CFG_BOOSTED : lrcb_pkg::CFG_UNBOOSTED)
                             : (v[6] ? lrcb_pkg::CFG_LADDER_SOFT : lrcb_pkg::CFG_LADDER_HARD);
    e.regulator_en = v[1:0] != 2'h0;
    e.vref_en = e.cfg != lrcb_pkg::CFG_LADDER_HARD;
    e.pump_on = e.cfg == lrcb_pkg::CFG_BOOSTED;
    e.bias_level = v[5:3];
    e.third_bias = v[2];
    e.flyback_gpio = e.cfg == lrcb_pkg::CFG_LADDER_SOFT;
    return e;
  endfunction
  // ****************************************
  // Bus cycles
  // ****************************************
  task wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 64);
    if (n >= 64) hang("write");
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er), "bresp");
  endtask
  task rd(input logic [3:0] a, input logic [31:0] m, e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 64);
    if (n >= 64) hang("read");
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
  endtask
  // Bias controls two edges later
  task bchk(input logic [7:0] v);
    lrcb_pkg::lrcb_bias_t e;
    repeat (2) @(posedge ref_clk_i);
    e = exp_bias(v);
    chk({22'h0, bias_ctrl_o}, {22'h0, e}, "bias controls");
  endtask
  // Pump clock lags its source two edges
  task pfollow(input int src);
    repeat (4) @(posedge ref_clk_i);
    repeat (64) begin
      @(posedge ref_clk_i);
      chk(32'(pump_clk_o), 32'((src == 1) ? rc_h[1] : (src == 2) ? t1_h[1] : 1'b0), "pump");
    end
  endtask
  // Cycles between two pump clock rises
  task period(output int c);
    int n, t0;
    logic p;
    t0 = -1;
    c = 0;
    p = 1'b1;
    for (n = 0; n < 4000 && c == 0; n++) begin
      @(posedge ref_clk_i);
      if (pump_clk_o && !p) begin
        if (t0 >= 0) c = n - t0;
        else t0 = n;
      end
      p = pump_clk_o;
    end
    if (c == 0) hang("pump period");
  endtask
  // Cycles and rises between two ticks
  task tick_gap(output int cyc, output int re, output int te);
    int n, a, b;
    n = 0;
    while (lcd_base_tick_o !== 1'b1 && n < 40000) begin
      @(posedge ref_clk_i);
      n++;
    end
    a = rc_rises;
    b = t1_rises;
    cyc = 0;
    do begin
      @(posedge ref_clk_i);
      cyc++;
    end while (lcd_base_tick_o !== 1'b1 && cyc < 40000);
    if (n >= 40000 || cyc >= 40000) hang("tick");
    re = rc_rises - a;
    te = t1_rises - b;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] v;
    int c, re, te;
    {rstn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {internal_rc_osc_i, timer1_osc_i, internal_fast_osc_i, timer1_osc_enable_i, sleep_i, fph_r} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
    {rc_h, t1_h, err_total, num_checks, rc_rises, t1_rises} = '0;
    void'($urandom(82));
    repeat (8) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(4'h0, 32'hffffffff, 32'h3c, 2'h0);
    rd(4'h4, 32'h3, 32'h0, 2'h0);
    bchk(8'h3c);
    $display("reset values done");
    wr(4'h0, 8'hff, 4'hf, 2'h0);
    rd(4'h0, 32'hffffffff, 32'h7f, 2'h0);
    bchk(8'h7f);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[1:0] = 2'(i);
      v[6] = i[2];
      wr(4'h0, v, 4'hf, 2'h0);
      rd(4'h0, 32'hffffffff, {24'h0, v & 8'h7f}, 2'h0);
      bchk(v);
    end
    wr(4'h0, 8'h00, 4'h0, 2'h0);
    rd(4'h0, 32'hff, {24'h0, v & 8'h7f}, 2'h0);
    wr(4'h8, 8'h55, 4'hf, lrcb_pkg::RESP_SLVERR);
    rd(4'hc, 32'hffffffff, 32'h0, lrcb_pkg::RESP_SLVERR);
    rd(4'h0, 32'hff, {24'h0, v & 8'h7f}, 2'h0);
    $display("register tests done");
    wr(4'h0, 8'h43, 4'hf, 2'h0);
    pfollow(1);
    wr(4'h0, 8'h41, 4'hf, 2'h0);
    pfollow(2);
    wr(4'h0, 8'h42, 4'hf, 2'h0);
    period(c);
    chk(32'(c), 32'd1024, "fast pump period");
    wr(4'h0, 8'h40, 4'hf, 2'h0);
    pfollow(0);
    wr(4'h0, 8'h03, 4'hf, 2'h0);
    pfollow(0);
    $display("pump clock tests done");
    repeat (2) @(posedge ref_clk_i);
    chk(32'(seg32_available_o), 32'h1, "seg32 free");
    timer1_osc_enable_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk(32'(seg32_available_o), 32'h0, "seg32 enable");
    timer1_osc_enable_i <= 1'b0;
    wr(4'h0, 8'h01, 4'hf, 2'h0);
    repeat (2) @(posedge ref_clk_i);
    chk(32'(seg32_available_o), 32'h0, "seg32 pump select");
    rd(4'h4, 32'h10, 32'h0, 2'h0);
    $display("segment tests done");
    sleep_i <= 1'b1;
    wr(4'h4, 8'h01, 4'hf, 2'h0);
    tick_gap(c, re, te);
    chk(32'(te), 32'd32, "timer1 tick");
    for (int s = 2; s < 4; s++) begin
      wr(4'h4, 8'(s), 4'hf, 2'h0);
      tick_gap(c, re, te);
      chk(32'(re), 32'd32, "rc tick");
    end
    sleep_i <= 1'b0;
    wr(4'h4, 8'h00, 4'hf, 2'h0);
    tick_gap(c, re, te);
    chk(32'(c), 32'd32768, "system tick");
    $display("timing tests done");
    end_sim();
  end
endmodule
`default_nettype wire
